// ---- pha_host_adapter.sv ----
// pci host adapter: arbiter, target decode, pio master, interrupt routing
`timescale 1ns/1ps
`include "pha_map.svh"
module pha_host_adapter #(
  parameter logic [31:0] DMA_BASE = 32'h0000_0000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pci_clk,
  input wire logic [4:0] slot_hi_grp,
  input wire pha_pkg::pha_slot_int_t int_n,
  input wire logic pio_req,
  input wire pha_pkg::pha_pio_req_t pio_cmd,
  output logic pio_busy,
  output logic pio_done,
  output logic pio_err,
  output logic [31:0] pio_rdata,
  output logic dma_valid,
  output logic [29:0] dma_phys,
  output logic dma_write,
  output logic [7:0] host_irq,
  input wire logic [4:0] pci_req_n,
  output logic [4:0] pci_gnt_n,
  input wire pha_pkg::pha_tgt_t tgt,
  output logic tgt_claim,
  output logic tgt_ack64_n,
  output logic mst_valid,
  output pha_pkg::pha_pio_req_t mst_cmd,
  output logic mst_req64_n,
  input wire logic mst_done,
  input wire logic [31:0] mst_rdata
);
  import pha_pkg::*;

  pha_host_st_t hs_q;
  pha_host_st_t hs_d;
  pha_pci_st_t ps_q;
  pha_pci_st_t ps_d;
  pha_slot_int_t act;
  logic [4:0] req;
  logic [4:0] hi_req;
  logic [4:0] lo_req;
  logic [4:0] hi_top;
  logic [4:0] lo_pick;
  logic [4:0] rr_hot;
  logic arb_now;
  logic [31:0] dma_off;
  logic tgt_hit;
  logic dma_busy;
  logic prst_n;

  function automatic logic [31:0] swap32(input logic [31:0] d);
    swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // host clock domain
  always_comb
  begin
    hs_d = hs_q;
    hs_d.done = 1'b0;
    hs_d.err = 1'b0;
    hs_d.dma_valid = 1'b0;
    // interrupt pins: three flops, change once last two agree
    hs_d.int_s1 = int_n;
    hs_d.int_s2 = hs_q.int_s1;
    hs_d.int_s3 = hs_q.int_s2;
    hs_d.int_st = (hs_q.int_s3 & ~(hs_q.int_s2 ^ hs_q.int_s3)) |
                  (hs_q.int_st & (hs_q.int_s2 ^ hs_q.int_s3));
    hs_d.irq[0] = act[0][`PHA_INTA];
    hs_d.irq[1] = act[1][`PHA_INTB];
    hs_d.irq[2] = act[2][`PHA_INTA];
    hs_d.irq[3] = act[3][`PHA_INTA];
    hs_d.irq[4] = act[4][`PHA_INTA];
    hs_d.irq[5] = act[2][`PHA_INTB] | act[3][`PHA_INTC] |
                  act[4][`PHA_INTD];
    hs_d.irq[6] = act[2][`PHA_INTC] | act[3][`PHA_INTD] |
                  act[4][`PHA_INTB];
    hs_d.irq[7] = act[2][`PHA_INTD] | act[3][`PHA_INTB] |
                  act[4][`PHA_INTC];
    // pio handshake toward the pci domain
    hs_d.ack_s1 = ps_q.ack_tgl;
    hs_d.ack_s2 = hs_q.ack_s1;
    hs_d.ack_s3 = hs_q.ack_s2;
    case (hs_q.pst)
      PHA_PIO_IDLE:
      begin
        if (pio_req)
        begin
          if (pio_cmd.addr < `PHA_PIO_BASE)
          begin
            hs_d.err = 1'b1;
          end
          else
          begin
            hs_d.req.write = pio_cmd.write;
            hs_d.req.addr = pio_cmd.addr;
            hs_d.req.data = swap32(pio_cmd.data);
            hs_d.req.be = {pio_cmd.be[0], pio_cmd.be[1], pio_cmd.be[2],
                           pio_cmd.be[3]};
            hs_d.req_tgl = ~hs_q.req_tgl;
            hs_d.pst = PHA_PIO_WAIT;
          end
        end
      end
      PHA_PIO_WAIT:
      begin
        if (hs_q.ack_s2 == hs_q.ack_s3 && hs_q.ack_s3 == hs_q.req_tgl)
        begin
          hs_d.rdata = swap32(ps_q.rdata);
          hs_d.done = 1'b1;
          hs_d.pst = PHA_PIO_IDLE;
        end
      end
      default:
      begin
        hs_d.pst = PHA_PIO_IDLE;
      end
    endcase
    // dma address event from the pci domain
    hs_d.dma_s1 = ps_q.dma_tgl;
    hs_d.dma_s2 = hs_q.dma_s1;
    hs_d.dma_s3 = hs_q.dma_s2;
    if (hs_q.dma_s2 == hs_q.dma_s3 && hs_q.dma_s3 != hs_q.dma_ack_tgl)
    begin
      hs_d.dma_phys = ps_q.dma_phys;
      hs_d.dma_write = ps_q.dma_write;
      hs_d.dma_valid = 1'b1;
      hs_d.dma_ack_tgl = hs_q.dma_s3;
    end
    if (!reset_n)
    begin
      hs_d = '0;
      hs_d.int_s1 = '1;
      hs_d.int_s2 = '1;
      hs_d.int_s3 = '1;
      hs_d.int_st = '1;
    end
  end

  assign act = ~hs_q.int_st;

  always_ff @(posedge clk)
  begin
    hs_q <= hs_d;
  end

  assign pio_busy = (hs_q.pst == PHA_PIO_WAIT);
  assign pio_done = hs_q.done;
  assign pio_err = hs_q.err;
  assign pio_rdata = hs_q.rdata;
  assign dma_valid = hs_q.dma_valid;
  assign dma_phys = hs_q.dma_phys;
  assign dma_write = hs_q.dma_write;
  assign host_irq = hs_q.irq;

  //////////////////////////////////////////////////////////////////////////
  // pci clock domain: arbiter
  assign prst_n = ps_q.rs2;
  assign req = ~pci_req_n;
  assign hi_req = req & ps_q.grp;
  assign lo_req = req & ~ps_q.grp;
  assign arb_now = ((~ps_q.gnt_n & req) == 5'h00);

  always_comb
  begin
    hi_top = 5'h00;
    for (int i = 0; i < `PHA_NSLOT; i++)
    begin
      if (hi_req[i])
      begin
        hi_top = 5'(1 << i);
      end
    end
  end

  always_comb
  begin
    int idx;
    lo_pick = 5'h00;
    idx = 0;
    rr_hot = 5'(1 << ps_q.rr);
    for (int k = `PHA_NSLOT; k >= 1; k--)
    begin
      idx = (int'(ps_q.rr) + k) % `PHA_NSLOT;
      if (lo_req[idx])
      begin
        lo_pick = 5'(1 << idx);
      end
    end
  end

  // target decode: only the 32-bit address phase is looked at
  assign dma_off = tgt.addr - DMA_BASE;
  assign dma_busy = (ps_q.dma_tgl != ps_q.dack_s3) ||
                    (ps_q.dack_s2 != ps_q.dack_s3);
  assign tgt_hit = tgt.start && tgt.cmd != `PHA_CMD_DAC &&
                   (tgt.cmd == `PHA_CMD_MRD || tgt.cmd == `PHA_CMD_MWR) &&
                   dma_off[`PHA_DMA_TOP] == 2'b00 && !dma_busy;

  always_comb
  begin
    ps_d = ps_q;
    ps_d.rs1 = reset_n;
    ps_d.rs2 = ps_q.rs1;
    // group register crossing
    ps_d.grp_s1 = slot_hi_grp;
    ps_d.grp_s2 = ps_q.grp_s1;
    ps_d.grp_s3 = ps_q.grp_s2;
    // whole word applied only once two samples agree, never torn
    if (ps_q.grp_s2 == ps_q.grp_s3)
    begin
      ps_d.grp = ps_q.grp_s3;
    end
    if (arb_now)
    begin
      if (hi_req != 5'h00)
      begin
        ps_d.gnt_n = ~hi_top;
      end
      else
      begin
        ps_d.gnt_n = ~lo_pick;
        for (int i = 0; i < `PHA_NSLOT; i++)
        begin
          if (lo_pick[i])
          begin
            ps_d.rr = 3'(i);
          end
        end
      end
    end
    // pio master, always a single 32-bit data phase
    ps_d.req_s1 = hs_q.req_tgl;
    ps_d.req_s2 = ps_q.req_s1;
    ps_d.req_s3 = ps_q.req_s2;
    ps_d.req64_n = 1'b1;
    case (ps_q.mst)
      PHA_MST_IDLE:
      begin
        if (ps_q.req_s2 == ps_q.req_s3 && ps_q.req_s3 != ps_q.ack_tgl)
        begin
          ps_d.mreq = hs_q.req;
          ps_d.mst_valid = 1'b1;
          ps_d.mst = PHA_MST_BUSY;
        end
      end
      PHA_MST_BUSY:
      begin
        if (mst_done)
        begin
          ps_d.rdata = mst_rdata;
          ps_d.mst_valid = 1'b0;
          ps_d.ack_tgl = ps_q.req_s3;
          ps_d.mst = PHA_MST_IDLE;
        end
      end
      default:
      begin
        ps_d.mst = PHA_MST_IDLE;
      end
    endcase
    // target claim, never widened to 64 bits
    ps_d.ack64_n = 1'b1;
    ps_d.claim = tgt_hit;
    ps_d.dack_s1 = hs_q.dma_ack_tgl;
    ps_d.dack_s2 = ps_q.dack_s1;
    ps_d.dack_s3 = ps_q.dack_s2;
    if (tgt_hit)
    begin
      ps_d.dma_phys = dma_off[29:0];
      ps_d.dma_write = tgt.cmd[`PHA_CMD_WR_BIT];
      ps_d.dma_tgl = ~ps_q.dma_tgl;
    end
    if (!prst_n)
    begin
      ps_d = '0;
      ps_d.rs1 = reset_n;
      ps_d.rs2 = ps_q.rs1;
      ps_d.gnt_n = '1;
      ps_d.req64_n = 1'b1;
      ps_d.ack64_n = 1'b1;
    end
  end

  always_ff @(posedge pci_clk)
  begin
    ps_q <= ps_d;
  end

  assign pci_gnt_n = ps_q.gnt_n;
  assign tgt_claim = ps_q.claim;
  assign tgt_ack64_n = ps_q.ack64_n;
  assign mst_valid = ps_q.mst_valid;
  assign mst_cmd = ps_q.mreq;
  assign mst_req64_n = ps_q.req64_n;

  //////////////////////////////////////////////////////////////////////////
  // assertions
  // pci checks also held off by the host reset until the sync settles
  a_no_dac_claim: assert property (@(posedge pci_clk)
    disable iff (!reset_n || !prst_n)
    tgt.start && tgt.cmd == `PHA_CMD_DAC |=> !tgt_claim)
    else $error("dual address cycle was claimed");
  a_no_wide_ack: assert property (@(posedge pci_clk)
    disable iff (!reset_n || !prst_n)
    tgt.start && !tgt.req64_n |=> tgt_ack64_n [*4])
    else $error("64-bit acknowledge asserted");
  a_mst_narrow: assert property (@(posedge pci_clk)
    disable iff (!reset_n || !prst_n)
    mst_valid |-> mst_req64_n)
    else $error("master requested a 64-bit transfer");
  a_gnt_single: assert property (@(posedge pci_clk)
    disable iff (!reset_n || !prst_n)
    $onehot0(~pci_gnt_n))
    else $error("more than one grant");
  a_hi_first: assert property (@(posedge pci_clk)
    disable iff (!reset_n || !prst_n)
    arb_now && hi_req != 5'h00
    |=> (~pci_gnt_n & $past(hi_req)) != 5'h00)
    else $error("lower group granted over higher group");
  a_hi_fixed: assert property (@(posedge pci_clk)
    disable iff (!reset_n || !prst_n)
    arb_now && hi_req != 5'h00 |=> ~pci_gnt_n == $past(hi_top))
    else $error("higher group not granted to highest slot");
  a_rr_rotate: assert property (@(posedge pci_clk)
    disable iff (!reset_n || !prst_n)
    arb_now && hi_req == 5'h00 && (lo_req & ~rr_hot) != 5'h00
    |=> ~pci_gnt_n != $past(rr_hot))
    else $error("round robin repeated last grantee");
  a_dma_window: assert property (@(posedge pci_clk)
    disable iff (!reset_n || !prst_n)
    tgt_hit |=> tgt_claim && ps_q.dma_phys == $past(dma_off[29:0]))
    else $error("dma address not translated");
  a_pio_low_err: assert property (@(posedge clk)
    disable iff (!reset_n)
    pio_req && !pio_busy && pio_cmd.addr < `PHA_PIO_BASE
    |=> pio_err && !pio_busy)
    else $error("low pio address not refused");
  a_pio_swap: assert property (@(posedge clk)
    disable iff (!reset_n)
    pio_req && !pio_busy && pio_cmd.addr >= `PHA_PIO_BASE
    |=> pio_busy && hs_q.req.data == swap32($past(pio_cmd.data)))
    else $error("pio byte lanes not reversed");
  a_irq_own: assert property (@(posedge clk)
    disable iff (!reset_n)
    !int_n[2][`PHA_INTA] [*6] |=> host_irq[2])
    else $error("slot 2 first pin not on its line");
  a_irq_spiral: assert property (@(posedge clk)
    disable iff (!reset_n)
    !int_n[3][`PHA_INTB] [*6] |=> host_irq[7])
    else $error("slot 3 pin b not on line 7");

  c_hi_grant: cover property (@(posedge pci_clk)
    disable iff (!reset_n || !prst_n)
    arb_now && hi_req != 5'h00 && lo_req != 5'h00);
  c_dma_event: cover property (@(posedge clk) disable iff (!reset_n)
    dma_valid);
  c_pio_done: cover property (@(posedge clk) disable iff (!reset_n)
    pio_done);
endmodule

// ---- pha_host_adapter_tb.sv ----
// self-checking bench for the pci host adapter
`timescale 1ns/1ps
module pha_host_adapter_tb;
  import pha_pkg::*;
  logic clk, pci_clk, reset_n, pio_req, pio_busy, pio_done, pio_err;
  logic dma_valid, dma_write, tgt_claim, tgt_ack64_n, mst_valid;
  logic mst_req64_n, mst_done, m64;
  logic [4:0] slot_hi_grp, pci_req_n, pci_gnt_n;
  logic [31:0] pio_rdata, mst_rdata;
  logic [29:0] dma_phys;
  logic [7:0] host_irq;
  logic [3:0] wait_cyc;
  pha_slot_int_t int_n;
  pha_pio_req_t pio_cmd, mst_cmd, mcap;
  pha_tgt_t tgt;
  int error_cnt, comparisons, rr, seed, s, p;
  int claim_cnt = 0;
  logic [30:0] dma_q[$];
  int lut[5][4] = '{'{0, -1, -1, -1}, '{-1, 1, -1, -1}, '{2, 5, 6, 7},
    '{3, 7, 5, 6}, '{4, 6, 7, 5}};

  pha_host_adapter #(.DMA_BASE(32'h0000_0000)) pha_host_adapter_i (
    .clk(clk), .reset_n(reset_n), .pci_clk(pci_clk),
    .slot_hi_grp(slot_hi_grp), .int_n(int_n), .pio_req(pio_req),
    .pio_cmd(pio_cmd), .pio_busy(pio_busy), .pio_done(pio_done),
    .pio_err(pio_err), .pio_rdata(pio_rdata), .dma_valid(dma_valid),
    .dma_phys(dma_phys), .dma_write(dma_write), .host_irq(host_irq),
    .pci_req_n(pci_req_n), .pci_gnt_n(pci_gnt_n), .tgt(tgt),
    .tgt_claim(tgt_claim), .tgt_ack64_n(tgt_ack64_n),
    .mst_valid(mst_valid), .mst_cmd(mst_cmd), .mst_req64_n(mst_req64_n),
    .mst_done(mst_done), .mst_rdata(mst_rdata));
  pha_pci_partner pha_pci_partner_i (.pci_clk(pci_clk),
    .mst_valid(mst_valid), .mst_cmd(mst_cmd), .wait_cyc(wait_cyc),
    .mst_done(mst_done), .mst_rdata(mst_rdata));

  ////////////////////////////////////////////////////////////////////////////
  initial clk = 1'b0;
  always #5 clk = ~clk;
  initial
  begin
    pci_clk = 1'b0;
    #1.7;
    forever #3 pci_clk = ~pci_clk;
  end
  always @(posedge pci_clk)
    if (tgt_claim === 1'b1)
      claim_cnt++;
  always @(posedge clk)
    if (dma_valid === 1'b1)
      dma_q.push_back({dma_phys, dma_write});
  always @(posedge pci_clk)
    if (mst_valid === 1'b1 && mst_done === 1'b1)
    begin
      mcap <= mst_cmd;
      m64 <= mst_req64_n;
    end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rev(logic [31:0] x);
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pio(logic w, logic [31:0] a, logic [3:0] wt);
    logic [31:0] d;
    logic [3:0] b;
    logic ok;
    int i;
    d = $random(seed);
    b = 4'($random(seed));
    ok = a >= 32'h8000_0000;
    wait_cyc = wt;
    @(posedge clk);
    #1;
    pio_cmd = '{w, a, d, b};
    pio_req = 1'b1;
    @(posedge clk);
    #1;
    pio_req = 1'b0;
    for (i = 0; i < 80 && pio_done !== 1'b1 && pio_err !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (pio_done !== 1'b1 && pio_err !== 1'b1)
    begin
      error_cnt++;
      $display("wrong value pio_done expected 1 seen timeout");
      stop_test;
    end
    chk("pio_err", !ok, pio_err);
    chk("pio_done", ok, pio_done);
    chk("pio_busy", 0, pio_busy);
    if (ok)
    begin
      chk("mst addr", a, mcap.addr);
      chk("mst be", {b[0], b[1], b[2], b[3]}, mcap.be);
      chk("mst write", w, mcap.write);
      chk("mst_req64_n", 1, m64);
      if (w)
        chk("mst data", rev(d), mcap.data);
      else
        chk("pio_rdata", rev(a ^ 32'h5a5a_0f0f), pio_rdata);
    end
  endtask
  task automatic tgt_op(logic [3:0] c, logic [31:0] a, logic r64);
    int n0;
    logic ok;
    n0 = claim_cnt;
    ok = (c == 4'h6 || c == 4'h7) && a < 32'h4000_0000;
    @(posedge pci_clk);
    #1;
    tgt = '{1'b1, c, a, r64};
    @(posedge pci_clk);
    #1;
    tgt.start = 1'b0;
    chk("tgt_ack64_n", 1, tgt_ack64_n);
    repeat (16) @(posedge pci_clk);
    #1;
    chk("claims", ok, claim_cnt - n0);
    chk("dma count", ok, dma_q.size());
    if (ok && dma_q.size() > 0)
      chk("dma_phys", {a[29:0], c[0]}, dma_q.pop_front());
  endtask
  task automatic arb_round(logic [4:0] hi);
    logic [4:0] pend;
    int e, k;
    slot_hi_grp = hi;
    repeat (6) @(posedge pci_clk);
    #1;
    pend = 5'h1f;
    pci_req_n = ~pend;
    repeat (5)
    begin
      e = -1;
      for (k = 4; k >= 0; k--)
        if (e < 0 && pend[k] && hi[k])
          e = k;
      for (k = 1; k <= 5; k++)
        if (e < 0 && pend[(rr + k) % 5] && !hi[(rr + k) % 5])
          e = (rr + k) % 5;
      if (!hi[e])
        rr = e;
      repeat (3) @(posedge pci_clk);
      #1;
      chk("pci_gnt_n", 5'h1f ^ 5'(1 << e), pci_gnt_n);
      pend[e] = 1'b0;
      pci_req_n = ~pend;
    end
  endtask
  task automatic irq_wait(logic [7:0] e);
    repeat (8) @(posedge clk);
    #1;
    chk("host_irq", e, host_irq);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 17454;
    error_cnt = 0;
    comparisons = 0;
    rr = 0;
    reset_n = 1'b0;
    pio_req = 1'b0;
    pio_cmd = '0;
    tgt = '0;
    pci_req_n = 5'h1f;
    slot_hi_grp = 5'h00;
    wait_cyc = 4'h0;
    int_n = '1;
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge clk);
    pio(1'b1, 32'h8000_0000, 4'h0);
    pio(1'b0, 32'h8000_0000, 4'h3);
    pio(1'b0, {1'b1, 31'($random(seed)) & 31'h7fff_fffc}, 4'h1);
    pio(1'b1, 32'h7fff_fffc, 4'h0);
    pio(1'b0, 32'h0000_0100, 4'h0);
    $display("test pio done");
    tgt_op(4'h6, 32'($random(seed)) & 32'h3fff_fffc, 1'b1);
    tgt_op(4'h7, 32'h3fff_fffc, 1'b0);
    tgt_op(4'h7, 32'h4000_0000, 1'b1);
    tgt_op(4'hd, 32'h0000_1000, 1'b1);
    $display("test target done");
    arb_round(5'b11100);
    arb_round(5'b00001);
    arb_round(5'b01010);
    $display("test arbiter done");
    @(posedge clk);
    #1;
    for (s = 0; s < 5; s++)
      for (p = 0; p < 4; p++)
      begin
        int_n[s][p] = 1'b0;
        irq_wait(lut[s][p] < 0 ? 8'h00 : 8'(1 << lut[s][p]));
        int_n = '1;
        irq_wait(8'h00);
      end
    int_n[2][1] = 1'b0;
    int_n[4][3] = 1'b0;
    irq_wait(8'h20);
    int_n[2][1] = 1'b1;
    irq_wait(8'h20);
    $display("test interrupts done");
    stop_test;
  end
endmodule

// ---- pha_map.svh ----
// address, command, interrupt and slot constants of the host adapter
`ifndef PHA_MAP_SVH
`define PHA_MAP_SVH
`define PHA_PIO_BASE 32'h8000_0000
`define PHA_LOW_MB 32'h0010_0000
`define PHA_CMD_DAC 4'hd
`define PHA_CMD_MRD 4'h6
`define PHA_CMD_MWR 4'h7
`define PHA_CMD_WR_BIT 0
`define PHA_DMA_TOP 31:30
`define PHA_INTA 0
`define PHA_INTB 1
`define PHA_INTC 2
`define PHA_INTD 3
`define PHA_NSLOT 5
`define PHA_NLINE 8
`endif

// ---- pha_pci_partner.sv ----
// far-side pci target answering the adapter's master cycles
`timescale 1ns/1ps
module pha_pci_partner (
  input wire logic pci_clk,
  input wire logic mst_valid,
  input wire pha_pkg::pha_pio_req_t mst_cmd,
  input wire logic [3:0] wait_cyc,
  output logic mst_done,
  output logic [31:0] mst_rdata
);
  import pha_pkg::*;
  int cnt;
  logic served;
  logic done_v;
  logic [31:0] rd_v;
  initial
  begin
    mst_done = 1'b0;
    mst_rdata = 32'h0;
    cnt = 0;
    served = 1'b0;
  end
  always @(posedge pci_clk)
  begin
    #1;
    done_v = 1'b0;
    // released lines never keep the last value
    rd_v = ~mst_rdata;
    if (mst_valid !== 1'b1)
      served = 1'b0;
    else if (!served && cnt < wait_cyc)
      cnt++;
    else if (!served)
    begin
      cnt = 0;
      served = 1'b1;
      done_v = 1'b1;
      rd_v = mst_cmd.addr ^ 32'h5a5a_0f0f;
    end
    // each line driven once per step
    mst_done = done_v;
    mst_rdata = rd_v;
  end
endmodule

// ---- pha_pkg.sv ----
// types shared by the host adapter
package pha_pkg;
  typedef logic [4:0][3:0] pha_slot_int_t;
  typedef enum logic [0:0] {PHA_PIO_IDLE = 1'b0, PHA_PIO_WAIT = 1'b1}
    pha_pio_st_t;
  typedef enum logic [0:0] {PHA_MST_IDLE = 1'b0, PHA_MST_BUSY = 1'b1}
    pha_mst_st_t;
  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } pha_pio_req_t;
  typedef struct packed {
    logic start;
    logic [3:0] cmd;
    logic [31:0] addr;
    logic req64_n;
  } pha_tgt_t;
  typedef struct packed {
    logic [19:0] int_s1;
    logic [19:0] int_s2;
    logic [19:0] int_s3;
    logic [19:0] int_st;
    logic [7:0] irq;
    pha_pio_st_t pst;
    logic req_tgl;
    pha_pio_req_t req;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic done;
    logic err;
    logic [31:0] rdata;
    logic dma_s1;
    logic dma_s2;
    logic dma_s3;
    logic dma_ack_tgl;
    logic dma_valid;
    logic [29:0] dma_phys;
    logic dma_write;
  } pha_host_st_t;
  typedef struct packed {
    logic rs1;
    logic rs2;
    logic [4:0] grp_s1;
    logic [4:0] grp_s2;
    logic [4:0] grp_s3;
    logic [4:0] grp;
    logic [4:0] gnt_n;
    logic [2:0] rr;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    pha_mst_st_t mst;
    logic mst_valid;
    pha_pio_req_t mreq;
    logic req64_n;
    logic ack_tgl;
    logic [31:0] rdata;
    logic claim;
    logic ack64_n;
    logic dma_tgl;
    logic [29:0] dma_phys;
    logic dma_write;
    logic dack_s1;
    logic dack_s2;
    logic dack_s3;
  } pha_pci_st_t;
endpackage
